/* File: dv/sfp_ctl_model.sv */
`timescale 1ns/1ps
`include "sfp_map.svh"

module sfp_ctl_model (
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	// Pins toward the port, selects packed as {1_n, 2, 3_n}
	output logic                        clock_qualify_n,
	output logic [2:0]                  cs,
	output logic                        write_enable_n,
	output logic                        burst_advance,
	output logic [`SFP_LANES-1:0]       byte_lane_write_select_n,
	output logic [`SFP_ADDR_W-1:0]      addr,
	output logic                        output_enable_n,
	output logic                        sleep_request,
	output logic                        burst_interleave,
	output logic [`SFP_DATA_W-1:0]      dq_in,
	// What the port should show after the last edge
	output logic                        rd_v,
	output logic                        idle_v,
	output logic                        wph,
	output logic                        rd_oe,
	output logic [`SFP_DATA_W-1:0]      rd_exp
);
	logic [35:0] sh [logic [18:0]];
	logic [35:0] pd;
	logic [35:0] v;
	logic [18:0] base;
	logic [18:0] wa;
	logic [18:0] ca;
	logic [3:0]  wl;
	logic [1:0]  bt;
	logic        dp, hd, lst, lw, s1, s2, o1, o2, m1, m2;

	// Quiet pins at start; sleep kept low unless a test asks for it
	initial
	begin
		{clock_qualify_n, cs, write_enable_n, burst_advance} = 6'h1a;
		byte_lane_write_select_n = 4'hf;
		addr = '0;
		dq_in = '0;
		pd = '0;
		{output_enable_n, sleep_request, burst_interleave} = 3'h0;
	end

	// One command per cycle; deselect drawn from chip_select_1_n high or chip_select_3_n high
	task automatic issue(input int op, input logic [18:0] a, input logic [3:0] ln,
		input logic [35:0] d, input logic sus);
		@(negedge clk);
		clock_qualify_n = sus;
		cs = (op == 1 || op == 2) ? 3'h2 : ($urandom % 3 == 0 ? 3'h6 : 3'h3);
		write_enable_n = (op != 2);
		burst_advance = (op == 3);
		addr = a;
		byte_lane_write_select_n = ln;
		// Released bus toggles so stale data can never pass as a match
		dq_in = dp ? pd : ~dq_in;
		// Write bursts carry fresh data on every advance beat
		if ((op == 2 || op == 3) && !sus)
			pd = d;
	endtask

	// Asynchronous and static pins
	task automatic pins(input logic oe, input logic slp, input logic md);
		@(negedge clk);
		output_enable_n = oe;
		sleep_request = slp;
		burst_interleave = md;
	endtask

	// Reference memory and expected outcome of each qualified edge
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			{dp, lst, lw, rd_v, idle_v, wph, s1, s2, m1, m2} = '0;
			{o1, o2} = 2'h3;
		end
		else
		begin
			if (!clock_qualify_n)
			begin
				hd = dp;
				if (dp)
				begin
					v = sh.exists(wa) ? sh[wa] : 'x;
					for (int l = 0; l < 4; l++)
						if (!wl[l])
							v[9*l +: 9] = dq_in[9*l +: 9];
					sh[wa] = v;
				end
				{dp, rd_v, wph, idle_v} = '0;
				if (s2)
				begin
					// Sleep drops the burst, a later advance is idle
					idle_v = 1'h1;
					{lst, lw} = '0;
				end
				else if (burst_advance && (lst || lw))
				begin
					bt = bt + 2'h1;
					ca = {base[18:2], m2 ? base[1:0] ^ bt : base[1:0] + bt};
					rd_v = lst;
					dp = lw;
					wph = lw;
					wa = ca;
					wl = byte_lane_write_select_n;
				end
				else if (!burst_advance && cs == 3'h2)
				begin
					base = addr;
					ca = addr;
					bt = '0;
					lst = write_enable_n;
					lw = !write_enable_n;
					rd_v = write_enable_n;
					dp = !write_enable_n;
					wph = dp;
					wa = addr;
					wl = byte_lane_write_select_n;
				end
				else
				begin
					idle_v = !hd;
					{lst, lw} = '0;
				end
				if (rd_v)
					rd_exp = sh.exists(ca) ? sh[ca] : 'x;
			end
			// Sync flops run on every edge, suspended or not
			rd_oe = o2;
			{s2, s1, o2, o1} = {s1, sleep_request, o1, output_enable_n};
			{m2, m1} = {m1, burst_interleave};
		end
	end
endmodule

/* File: dv/sfp_tb.sv */
`timescale 1ns/1ps
`include "sfp_map.svh"

module testbench;
	logic        clk, rst_n, cqn, wen, adv, oen, slp, md, oe_n, wr_rdy, lp;
	logic        rd_v, idle_v, wph, rd_oe;
	logic [2:0]  cs;
	logic [3:0]  ln;
	logic [18:0] a;
	logic [18:0] pool [8];
	logic [35:0] din, dout, rd_exp;
	int          mismatches, num_checks, cyc;

	sfp_ctl_model m (
		.clk(clk), .rst_n(rst_n), .clock_qualify_n(cqn), .cs(cs), .write_enable_n(wen),
		.burst_advance(adv), .byte_lane_write_select_n(ln), .addr(a), .output_enable_n(oen),
		.sleep_request(slp), .burst_interleave(md), .dq_in(din), .rd_v(rd_v),
		.idle_v(idle_v), .wph(wph), .rd_oe(rd_oe), .rd_exp(rd_exp));

	sfp_port uut (
		.clk(clk), .rst_n(rst_n), .clock_qualify_n(cqn), .chip_select_1_n(cs[2]),
		.chip_select_2(cs[1]), .chip_select_3_n(cs[0]), .write_enable_n(wen),
		.burst_advance(adv), .byte_lane_write_select_n(ln), .addr(a),
		.output_enable_n(oen), .sleep_request(slp), .burst_interleave(md), .dq_in(din),
		.dq_out(dout), .dq_oe_n(oe_n), .write_ready(wr_rdy), .low_power(lp));

	// 20 MHz clock
	initial
	begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end

	task automatic check(input string nm, input logic [35:0] seen, input logic [35:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	function automatic logic [35:0] r36();
		logic [63:0] t;
		t = {$urandom, $urandom};
		return t[35:0];
	endfunction

	task automatic idle(input int n);
		repeat (n) m.issue(0, '0, 4'hf, '0, 1'h0);
	endtask

	// Hang guard, well above the few hundred cycles the run needs
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 4000)
		begin
			mismatches++;
			close_out();
		end
	end

	// Outputs judged half a cycle after each edge, once settled
	always @(negedge clk)
	begin
		if (rst_n && rd_v)
		begin
			check("read data", dout, rd_exp);
			check("read drive", oe_n, rd_oe);
			check("read power", lp, 1'h0);
		end
		if (rst_n && wph)
			check("write float", oe_n, 1'h1);
		if (rst_n && idle_v)
		begin
			check("idle float", oe_n, 1'h1);
			check("idle power", lp, 1'h1);
		end
		if (rst_n)
			check("write ready", wr_rdy, 1'h1);
	end

	initial
	begin
		logic [18:0] g;
		void'($urandom(32'h29b8_fd02));
		rst_n = 1'h0;
		repeat (3) @(posedge clk);
		@(negedge clk);
		rst_n = 1'h1;
		check("reset float", oe_n, 1'h1);
		check("reset power", lp, 1'h1);
		g = 19'($urandom);
		// One random aligned group and the topmost group of the array
		for (int i = 0; i < 4; i++)
		begin
			pool[i] = {g[18:2], 2'(i)};
			pool[i+4] = {17'h1_ffff, 2'(i)};
		end
		// Whole words first so every later read is defined
		for (int i = 0; i < 8; i++)
			m.issue(2, pool[i], 4'h0, r36(), 1'h0);
		// Random back to back mix, frozen edges sprinkled in
		repeat (300)
			m.issue($urandom % 3, pool[$urandom % 8], 4'($urandom), r36(),
				($urandom % 6) == 0);
		// Write data held over two frozen edges, then read straight back
		m.issue(2, pool[5], 4'h5, r36(), 1'h0);
		repeat (2) m.issue(1, pool[6], 4'h0, '0, 1'h1);
		m.issue(1, pool[5], 4'h0, '0, 1'h0);
		repeat (3) m.issue(2, pool[1], 4'h0, '0, 1'h1);
		idle(1);
		// Bursts from every start offset in both orders, wrapping once
		for (int b = 0; b < 2; b++)
		begin
			m.pins(1'h0, 1'h0, 1'(b));
			idle(4);
			for (int i = 0; i < 8; i++)
			begin
				m.issue(1, pool[i], 4'h0, '0, 1'h0);
				repeat (4) m.issue(3, 19'($urandom), 4'h0, '0, 1'h0);
			end
			// Write burst, all lanes on the load and random lanes on the three advances, then the whole group read back
			m.issue(2, pool[b*4+1], 4'h0, r36(), 1'h0);
			repeat (3) m.issue(3, '0, 4'($urandom), r36(), 1'h0);
			for (int i = 0; i < 4; i++)
				m.issue(1, pool[b*4+i], 4'h0, '0, 1'h0);
		end
		// Output enable off: reads must leave the bus floating
		m.pins(1'h1, 1'h0, 1'h0);
		idle(4);
		m.issue(1, pool[2], 4'h0, '0, 1'h0);
		m.pins(1'h0, 1'h0, 1'h0);
		idle(4);
		// Asleep: commands ignored, a write must not land
		m.pins(1'h0, 1'h1, 1'h0);
		idle(4);
		m.issue(2, pool[3], 4'h0, r36(), 1'h0);
		m.issue(1, pool[3], 4'h0, '0, 1'h0);
		m.pins(1'h0, 1'h0, 1'h0);
		idle(4);
		m.issue(1, pool[3], 4'h0, '0, 1'h0);
		idle(2);
		close_out();
	end
endmodule

/* File: verilog/sfp_fifo.sv */
`timescale 1ns/1ps

module sfp_fifo #(
	parameter int W = 8,
	parameter int D = 16,
	localparam int AW = $clog2(D)
) (
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                rst_n,
	// Fill side
	input  wire logic                in_valid,
	output logic                     in_ready,
	input  wire logic [W-1:0]        in_data,
	// Drain side
	output logic                     out_valid,
	input  wire logic                out_ready,
	output logic [W-1:0]             out_data,
	// Entries by age, index 0 oldest
	output logic [D-1:0][W-1:0]      view_data,
	output logic [D-1:0]             view_valid,
	output logic [AW:0]              level
);

	typedef struct packed
	{
		logic [AW-1:0] wr_ptr;
		logic [AW-1:0] rd_ptr;
		logic [AW:0]   count;
	} sfp_fifo_state_t;

	sfp_fifo_state_t st_q;
	sfp_fifo_state_t st_d;
	logic [W-1:0]    mem [D];
	logic            push;
	logic            pop;

	// Flags come from the count register only, never from the inputs
	assign in_ready  = (st_q.count != (AW+1)'(D));
	assign out_valid = (st_q.count != '0);
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	assign out_data  = mem[st_q.rd_ptr];
	assign level     = st_q.count;

	// Age-ordered view so a reader can see writes not yet drained
	for (genvar i = 0; i < D; i++)
	begin : g_view
		assign view_data[i]  = mem[st_q.rd_ptr + AW'(i)];
		assign view_valid[i] = ((AW+1)'(i) < st_q.count);
	end

	// Pointer and count update
	always_comb
	begin
		st_d = st_q;
		if (push)
			st_d.wr_ptr = st_q.wr_ptr + AW'(1);
		if (pop)
			st_d.rd_ptr = st_q.rd_ptr + AW'(1);
		case ({push, pop})
			2'b10:   st_d.count = st_q.count + (AW+1)'(1);
			2'b01:   st_d.count = st_q.count - (AW+1)'(1);
			default: st_d.count = st_q.count;
		endcase
	end

	// State register
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	// Storage, no reset needed
	always_ff @(posedge clk)
	begin
		if (push)
			mem[st_q.wr_ptr] <= in_data;
	end

endmodule

/* File: verilog/sfp_map.svh */
`ifndef SFP_MAP_SVH
`define SFP_MAP_SVH

// Array shape of the wide variant
`define SFP_ADDR_W 19
`define SFP_DATA_W 36
`define SFP_LANES 4
`define SFP_LANE_W 9
`define SFP_WORDS 524288

// Burst shape
`define SFP_BURST_W 2

// Write buffer shape and the free slots kept for words already in flight
`define SFP_FIFO_DEPTH 16
`define SFP_FIFO_HEADROOM 2

// Clock
`define SFP_CLK_PERIOD_NS 50

// Reset values
`define SFP_RST_OE_N 1'b1
`define SFP_RST_LOW_POWER 1'b1
`define SFP_RST_WR_READY 1'b1

`endif

/* File: verilog/sfp_pkg.sv */
`include "sfp_map.svh"

package sfp_pkg;

	// Operation held by the port for the current data phase
	typedef enum logic [1:0]
	{
		SFP_OP_IDLE  = 2'b00,
		SFP_OP_READ  = 2'b01,
		SFP_OP_WRITE = 2'b10
	} sfp_op_t;

	// One buffered write on its way to the array
	typedef struct packed
	{
		logic [`SFP_ADDR_W-1:0] addr;
		logic [`SFP_LANES-1:0]  lane_en;
		logic [`SFP_DATA_W-1:0] data;
	} sfp_wr_entry_t;

	// Whole state of the port
	typedef struct packed
	{
		logic                    oe_s1;
		logic                    oe_s2;
		logic                    slp_s1;
		logic                    slp_s2;
		logic                    md_s1;
		logic                    md_s2;
		sfp_op_t                 op;
		logic [`SFP_ADDR_W-1:0]  base_addr;
		logic [`SFP_BURST_W-1:0] beat;
		logic [`SFP_ADDR_W-1:0]  cur_addr;
		logic                    wr_pend;
		logic [`SFP_ADDR_W-1:0]  wr_addr;
		logic [`SFP_LANES-1:0]   wr_lane_en;
		logic                    rd_phase;
		logic [`SFP_DATA_W-1:0]  dout;
		logic                    dq_oe_n;
		logic                    low_power;
		logic                    wr_ready;
	} sfp_state_t;

	localparam sfp_state_t SFP_STATE_RST = '{
		oe_s1:     `SFP_RST_OE_N,
		oe_s2:     `SFP_RST_OE_N,
		op:        SFP_OP_IDLE,
		dq_oe_n:   `SFP_RST_OE_N,
		low_power: `SFP_RST_LOW_POWER,
		wr_ready:  `SFP_RST_WR_READY,
		default:   '0
	};

endpackage

/* File: verilog/sfp_port.sv */
// Operation
// - Array holds 512K words of 36 bits; the 1M x 18 variant is not built.
// - All synchronous pins are captured on the rising clock edge only.
// - Clock qualify high freezes command, burst and write state as if the cycle stretched; pin sync flops still run.
// - Reads and writes mix back to back, one word per cycle, no turnaround.
// - No wait states are ever inserted on any access.
// - Write enable requests writes; lane selects choose bytes; others stay unchanged.
// - Array writes are self-timed from registered request and data.
// - Outputs float during the data phase of a write, in step with clock.
// - Port drives its own output enables for reads and writes.
// - Chip selects sampled on the edge; output enable passes two sync flops, then floats bus.
// - Read data leaves a register, merged with buffered writes, valid in cycle after address edge.
// - Bursts run in linear or interleaved order, chosen by configuration pin.
// - Sleep or deselect puts the port into its low-power state.
// - Address sampled on rising edge selects one word of the whole array.
`timescale 1ns/1ps
`include "sfp_map.svh"

module sfp_port (
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	// Registered command pins
	input  wire logic                   clock_qualify_n,
	input  wire logic                   chip_select_1_n,
	input  wire logic                   chip_select_2,
	input  wire logic                   chip_select_3_n,
	input  wire logic                   write_enable_n,
	input  wire logic                   burst_advance,
	input  wire logic [`SFP_LANES-1:0]  byte_lane_write_select_n,
	input  wire logic [`SFP_ADDR_W-1:0] addr,
	// Asynchronous and static pins
	input  wire logic                   output_enable_n,
	input  wire logic                   sleep_request,
	input  wire logic                   burst_interleave,
	// Common data bus, split into its three signals
	input  wire logic [`SFP_DATA_W-1:0] dq_in,
	output logic [`SFP_DATA_W-1:0]      dq_out,
	output logic                        dq_oe_n,
	// Status
	output logic                        write_ready,
	output logic                        low_power
);

	localparam int AW = `SFP_ADDR_W;
	localparam int DW = `SFP_DATA_W;
	localparam int LN = `SFP_LANES;
	localparam int LW = `SFP_LANE_W;
	localparam int FD = `SFP_FIFO_DEPTH;
	localparam int EW = $bits(sfp_pkg::sfp_wr_entry_t);
	localparam int FLW = $clog2(FD) + 1;

	sfp_pkg::sfp_state_t    st_q;
	sfp_pkg::sfp_state_t    st_d;
	sfp_pkg::sfp_op_t       cmd_op;
	sfp_pkg::sfp_wr_entry_t push_entry;
	sfp_pkg::sfp_wr_entry_t drain_entry;
	sfp_pkg::sfp_wr_entry_t view_entry;
	logic                   cmd_sel;
	logic                   cmd_load;
	logic [AW-1:0]          cmd_addr;
	logic [1:0]             next_beat;
	logic [1:0]             low_bits;
	logic [DW-1:0]          arr_word;
	logic [DW-1:0]          rd_word;
	logic                   push_req;
	logic                   push_ok;
	logic                   pop;
	logic [FLW:0]           level_next;
	logic                   fifo_in_ready;
	logic                   fifo_out_valid;
	logic [EW-1:0]          fifo_out_data;
	logic [FD-1:0][EW-1:0]  fifo_view;
	logic [FD-1:0]          fifo_view_valid;
	logic [FLW-1:0]         fifo_level;

	// Outputs straight from the state register
	assign dq_out      = st_q.dout;
	assign dq_oe_n     = st_q.dq_oe_n;
	assign write_ready = st_q.wr_ready;
	assign low_power   = st_q.low_power;

	// Array split per byte lane so each lane writes on its own
	for (genvar l = 0; l < LN; l++)
	begin : g_lane
		logic [LW-1:0] mem [`SFP_WORDS];
		always_ff @(posedge clk)
		begin
			if (pop && drain_entry.lane_en[l])
				mem[drain_entry.addr] <= drain_entry.data[l*LW +: LW];
		end
		assign arr_word[l*LW +: LW] = mem[cmd_addr];
	end

	// Write data waits here when reads keep the array busy
	sfp_fifo #(
		.W (EW),
		.D (FD)
	) u_wbuf (
		.clk        (clk),
		.rst_n      (rst_n),
		.in_valid   (push_req),
		.in_ready   (fifo_in_ready),
		.in_data    (push_entry),
		.out_valid  (fifo_out_valid),
		.out_ready  (pop),
		.out_data   (fifo_out_data),
		.view_data  (fifo_view),
		.view_valid (fifo_view_valid),
		.level      (fifo_level)
	);

	assign drain_entry = fifo_out_data;

	// Command decode and read data path, one word each cycle
	always_comb
	begin
		cmd_sel   = ~chip_select_1_n & chip_select_2 & ~chip_select_3_n;
		cmd_op    = sfp_pkg::SFP_OP_IDLE;
		cmd_load  = 1'b0;
		next_beat = st_q.beat;
		cmd_addr  = st_q.cur_addr;
		low_bits  = st_q.base_addr[1:0];
		if (st_q.slp_s2)
			cmd_op = sfp_pkg::SFP_OP_IDLE;
		else if (burst_advance)
		begin
			// Burst keeps the last operation type and walks the low bits
			cmd_op    = st_q.op;
			next_beat = st_q.beat + 2'd1;
			if (st_q.md_s2)
				low_bits = st_q.base_addr[1:0] ^ next_beat;
			else
				low_bits = st_q.base_addr[1:0] + next_beat;
			cmd_addr = {st_q.base_addr[AW-1:2], low_bits};
		end
		else if (cmd_sel)
		begin
			cmd_load  = 1'b1;
			next_beat = 2'd0;
			cmd_addr  = addr;
			cmd_op    = write_enable_n ? sfp_pkg::SFP_OP_READ : sfp_pkg::SFP_OP_WRITE;
		end

		// Data phase of the previous write goes into the buffer
		push_req   = st_q.wr_pend & ~clock_qualify_n;
		push_ok    = push_req & fifo_in_ready;
		push_entry = '{addr: st_q.wr_addr, lane_en: st_q.wr_lane_en, data: dq_in};

		// Read merges buffered writes oldest first, so the newest wins
		rd_word    = arr_word;
		view_entry = '0;
		for (int i = 0; i < FD; i++)
		begin
			view_entry = fifo_view[i];
			if (fifo_view_valid[i] && view_entry.addr == cmd_addr)
				for (int l = 0; l < LN; l++)
					if (view_entry.lane_en[l])
						rd_word[l*LW +: LW] = view_entry.data[l*LW +: LW];
		end
		if (push_ok && st_q.wr_addr == cmd_addr)
			for (int l = 0; l < LN; l++)
				if (st_q.wr_lane_en[l])
					rd_word[l*LW +: LW] = dq_in[l*LW +: LW];

		// Drain only when no read holds the array; asleep it holds too
		pop = fifo_out_valid & ~clock_qualify_n & ~st_q.slp_s2 &
			(cmd_op != sfp_pkg::SFP_OP_READ);
		level_next = (FLW+1)'(fifo_level) + (FLW+1)'(push_ok) - (FLW+1)'(pop);
	end

	// Next state
	always_comb
	begin
		st_d = st_q;
		// Async pins cross on two flops; a floating sleep pin is not handled
		st_d.oe_s1  = output_enable_n;
		st_d.oe_s2  = st_q.oe_s1;
		st_d.slp_s1 = sleep_request;
		st_d.slp_s2 = st_q.slp_s1;
		st_d.md_s1  = burst_interleave;
		st_d.md_s2  = st_q.md_s1;
		if (!clock_qualify_n)
		begin
			st_d.op       = cmd_op;
			st_d.beat     = next_beat;
			st_d.cur_addr = cmd_addr;
			if (cmd_load)
				st_d.base_addr = addr;
			st_d.wr_pend  = 1'b0;
			st_d.rd_phase = 1'b0;
			case (cmd_op)
				sfp_pkg::SFP_OP_READ:
				begin
					st_d.rd_phase = 1'b1;
					st_d.dout     = rd_word;
				end
				sfp_pkg::SFP_OP_WRITE:
				begin
					st_d.wr_pend    = 1'b1;
					st_d.wr_addr    = cmd_addr;
					st_d.wr_lane_en = ~byte_lane_write_select_n;
				end
				sfp_pkg::SFP_OP_IDLE:
					st_d.op = sfp_pkg::SFP_OP_IDLE;
				default:
					st_d.op = sfp_pkg::SFP_OP_IDLE;
			endcase
			st_d.low_power = st_q.slp_s2 | (cmd_op == sfp_pkg::SFP_OP_IDLE);
			// Headroom covers the write whose data arrives after ready drops
			st_d.wr_ready = (level_next <= (FLW+1)'(FD - `SFP_FIFO_HEADROOM));
		end
		// Drivers follow the phase; output enable overrides regardless of clock
		st_d.dq_oe_n = ~(st_d.rd_phase & ~st_q.oe_s2);
	end

	// State register
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			st_q <= sfp_pkg::SFP_STATE_RST;
		else
			st_q <= st_d;
	end

	// Checks on the port behaviour
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	logic new_rd;
	logic new_wr;
	assign new_rd = ~clock_qualify_n & (cmd_op == sfp_pkg::SFP_OP_READ);
	assign new_wr = ~clock_qualify_n & (cmd_op == sfp_pkg::SFP_OP_WRITE);

	property p_freeze;
		clock_qualify_n |=> $stable(dq_out) && $stable(st_q.wr_pend) && $stable(st_q.cur_addr);
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("state moved while clock qualify was high");

	property p_read_phase;
		new_rd |=> st_q.rd_phase && (dq_oe_n == $past(st_q.oe_s2));
	endproperty
	a_read_phase: assert property (p_read_phase)
		else $error("read did not drive data in the next cycle");

	property p_write_float;
		new_wr |=> dq_oe_n && st_q.wr_pend;
	endproperty
	a_write_float: assert property (p_write_float)
		else $error("drivers not floating during write data phase");

	property p_oe_async;
		st_q.oe_s2 |=> dq_oe_n;
	endproperty
	a_oe_async: assert property (p_oe_async)
		else $error("output enable high did not float the bus");

	property p_deselect;
		!clock_qualify_n && !cmd_sel && !burst_advance |=> low_power && !st_q.rd_phase;
	endproperty
	a_deselect: assert property (p_deselect)
		else $error("deselect did not reach low power");

	property p_sleep;
		st_q.slp_s2 && !clock_qualify_n |=> low_power && dq_oe_n && !st_q.wr_pend;
	endproperty
	a_sleep: assert property (p_sleep)
		else $error("sleep did not reach low power");

	property p_linear;
		st_q.op != sfp_pkg::SFP_OP_IDLE && !st_q.md_s2 && !st_q.slp_s2 &&
			!clock_qualify_n && burst_advance
			|=> st_q.cur_addr[1:0] == 2'($past(st_q.base_addr[1:0]) + $past(st_q.beat) + 2'd1);
	endproperty
	a_linear: assert property (p_linear)
		else $error("linear burst address wrong");

	property p_interleave;
		st_q.op != sfp_pkg::SFP_OP_IDLE && st_q.md_s2 && !st_q.slp_s2 &&
			!clock_qualify_n && burst_advance
			|=> st_q.cur_addr[1:0] == ($past(st_q.base_addr[1:0]) ^ 2'($past(st_q.beat) + 2'd1));
	endproperty
	a_interleave: assert property (p_interleave)
		else $error("interleaved burst address wrong");

	property p_lanes;
		new_wr |=> st_q.wr_lane_en == ~$past(byte_lane_write_select_n);
	endproperty
	a_lanes: assert property (p_lanes)
		else $error("lane enables not taken from selects");

	property p_addr;
		new_rd && cmd_load |=> st_q.cur_addr == $past(addr) && st_q.beat == 2'd0;
	endproperty
	a_addr: assert property (p_addr)
		else $error("load address not captured");

	property p_b2b;
		new_wr ##1 (new_rd && fifo_in_ready) |=> st_q.rd_phase && $past(push_ok);
	endproperty
	a_b2b: assert property (p_b2b)
		else $error("write then read lost a cycle");

	property p_drain;
		fifo_out_valid && !clock_qualify_n && !st_q.slp_s2 && !new_rd |-> pop;
	endproperty
	a_drain: assert property (p_drain)
		else $error("idle array did not drain a buffered write");

endmodule
